// file: rtl/tccu_pkg.sv
// shared constants for the 16-bit timer compare and capture unit
package tccu_pkg;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_CH = 3;
    localparam int MODE_W = 4;
    localparam int ACT_W = 2;

    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // waveform_mode_select encodings
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PC8 = 4'h1;
    localparam logic [3:0] MODE_PC9 = 4'h2;
    localparam logic [3:0] MODE_PC10 = 4'h3;
    localparam logic [3:0] MODE_CLR_CMPA = 4'h4;
    localparam logic [3:0] MODE_FAST8 = 4'h5;
    localparam logic [3:0] MODE_FAST9 = 4'h6;
    localparam logic [3:0] MODE_FAST10 = 4'h7;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
    localparam logic [3:0] MODE_PC_CAP = 4'hA;
    localparam logic [3:0] MODE_PC_CMPA = 4'hB;
    localparam logic [3:0] MODE_CLR_CAP = 4'hC;
    localparam logic [3:0] MODE_RESERVED = 4'hD;
    localparam logic [3:0] MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

    // output_action_select encodings
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    localparam int CH_A = 0;
endpackage : tccu_pkg

// file: rtl/tccu_channel.sv
// one output compare channel: compare register pair, match, flag and waveform bit
`timescale 1ns/100ps
module tccu_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] wdata16,
    input wire logic cmp_wr,
    input wire logic dbuf_en,
    input wire logic load_evt,
    input wire logic match_en,
    input wire logic top_evt,
    input wire logic counting_down,
    input wire logic is_pwm,
    input wire logic dual_slope,
    input wire logic [1:0] action,
    input wire logic force_strobe,
    input wire logic flag_clear,
    input wire logic irq_ack,
    input wire logic irq_enable,
    input wire logic [15:0] count,
    output logic [15:0] compare_active,
    output logic [15:0] compare_cpu,
    output logic match,
    output logic flag,
    output logic irq,
    output logic wave,
    output logic wave_override
);
    typedef struct packed {
        logic [15:0] act;
        logic [15:0] buff;
        logic flag;
        logic wave;
    } tccu_ch_state_t;

    tccu_ch_state_t s_q;
    tccu_ch_state_t s_d;
    logic hit;

    assign match = (count == s_q.act);
    assign hit = match_en && match;

    always_comb begin
        s_d = s_q;
        // buffered value moves to the active register only at the update point
        if (dbuf_en && load_evt) begin
            s_d.act = s_q.buff;
        end
        // the staged high byte and the low byte land together
        if (cmp_wr) begin
            s_d.buff = wdata16;
            if (!dbuf_en) begin
                s_d.act = wdata16;
            end
        end
        // flag sets on the tick after equality; set wins over clear
        if (flag_clear || irq_ack) begin
            s_d.flag = 1'b0;
        end
        if (hit) begin
            s_d.flag = 1'b1;
        end
        // action bits are read live, never buffered
        if (!is_pwm) begin
            if (hit || force_strobe) begin
                case (action)
                    tccu_pkg::ACT_TOGGLE: s_d.wave = !s_q.wave;
                    tccu_pkg::ACT_CLEAR: s_d.wave = 1'b0;
                    tccu_pkg::ACT_SET: s_d.wave = 1'b1;
                    default: s_d.wave = s_q.wave;
                endcase
            end
        end else if (dual_slope) begin
            // force is ignored in pwm modes
            if (hit) begin
                case (action)
                    tccu_pkg::ACT_CLEAR: s_d.wave = counting_down;
                    tccu_pkg::ACT_SET: s_d.wave = !counting_down;
                    default: s_d.wave = s_q.wave;
                endcase
            end
        end else begin
            if (hit) begin
                case (action)
                    tccu_pkg::ACT_CLEAR: s_d.wave = 1'b1;
                    tccu_pkg::ACT_SET: s_d.wave = 1'b0;
                    default: s_d.wave = s_q.wave;
                endcase
            end
            // the top wrap ends the pulse; it overrides a match in the same tick
            if (top_evt) begin
                case (action)
                    tccu_pkg::ACT_CLEAR: s_d.wave = 1'b0;
                    tccu_pkg::ACT_SET: s_d.wave = 1'b1;
                    default: s_d.wave = s_d.wave;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.act <= tccu_pkg::CNT_RESET;
            s_q.buff <= tccu_pkg::CNT_RESET;
            s_q.flag <= 1'b0;
            s_q.wave <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign compare_active = s_q.act;
    assign compare_cpu = dbuf_en ? s_q.buff : s_q.act;
    assign flag = s_q.flag;
    assign irq = s_q.flag && irq_enable;
    assign wave = s_q.wave;
    assign wave_override = (action != tccu_pkg::ACT_NONE);
endmodule : tccu_channel

// file: rtl/tccu_top.sv
// 16-bit timer core with three output compare channels and an input capture register
// Function
// - new capture event overwrites held value unless capture defines top
// - compare full counter against compare value continuously
// - compare flag sets one timer cycle later
// - enabled flag interrupts; ack or one clears
// - waveform output from match, mode, top
// - three channels; channel A may define top
// - double buffer in pwm, not normal/clear
// - buffer loads active register at top/bottom
// - cpu writes buffer or active register directly
// - compare value changes only by cpu write
// - high byte staged, low byte loads all
// - force acts like match outside pwm modes, no flag/counter
// - counter write blocks next timer cycle match
// - counter written at top skips top match
// - waveform bit kept across mode change
// - action bits act immediately, unbuffered
// - reset clears every waveform bit
// - action zero holds; nonzero overrides pin
// - modes 4 and 12 clear on match
`timescale 1ns/100ps
module tccu_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TIMER_TICK,
    input wire logic [3:0] WAVEFORM_MODE_SELECT,
    input wire logic [1:0] OUTPUT_ACTION_SELECT_A,
    input wire logic [1:0] OUTPUT_ACTION_SELECT_B,
    input wire logic [1:0] OUTPUT_ACTION_SELECT_C,
    input wire logic COMPARE_IRQ_ENABLE_A,
    input wire logic COMPARE_IRQ_ENABLE_B,
    input wire logic COMPARE_IRQ_ENABLE_C,
    input wire logic CAPTURE_IRQ_ENABLE,
    input wire logic [7:0] BYTE_WDATA,
    input wire logic COMPARE_HIGH_WR_A,
    input wire logic COMPARE_HIGH_WR_B,
    input wire logic COMPARE_HIGH_WR_C,
    input wire logic COMPARE_LOW_WR_A,
    input wire logic COMPARE_LOW_WR_B,
    input wire logic COMPARE_LOW_WR_C,
    input wire logic COUNT_HIGH_WR,
    input wire logic COUNT_LOW_WR,
    input wire logic CAPTURE_HIGH_WR,
    input wire logic CAPTURE_LOW_WR,
    input wire logic FORCE_COMPARE_STROBE_A,
    input wire logic FORCE_COMPARE_STROBE_B,
    input wire logic FORCE_COMPARE_STROBE_C,
    input wire logic COMPARE_FLAG_CLEAR_A,
    input wire logic COMPARE_FLAG_CLEAR_B,
    input wire logic COMPARE_FLAG_CLEAR_C,
    input wire logic COMPARE_IRQ_ACK_A,
    input wire logic COMPARE_IRQ_ACK_B,
    input wire logic COMPARE_IRQ_ACK_C,
    input wire logic CAPTURE_EVENT,
    input wire logic CAPTURE_FLAG_CLEAR,
    input wire logic CAPTURE_IRQ_ACK,
    output logic [15:0] COUNT_VALUE,
    output logic [15:0] CAPTURE_VALUE,
    output logic CAPTURE_FLAG,
    output logic CAPTURE_IRQ,
    output logic [15:0] COMPARE_VALUE_A,
    output logic [15:0] COMPARE_VALUE_B,
    output logic [15:0] COMPARE_VALUE_C,
    output logic COMPARE_MATCH_A,
    output logic COMPARE_MATCH_B,
    output logic COMPARE_MATCH_C,
    output logic COMPARE_FLAG_A,
    output logic COMPARE_FLAG_B,
    output logic COMPARE_FLAG_C,
    output logic COMPARE_IRQ_A,
    output logic COMPARE_IRQ_B,
    output logic COMPARE_IRQ_C,
    output logic WAVE_OUTPUT_A,
    output logic WAVE_OUTPUT_B,
    output logic WAVE_OUTPUT_C,
    output logic WAVE_OVERRIDE_A,
    output logic WAVE_OVERRIDE_B,
    output logic WAVE_OVERRIDE_C
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0] temp;
        logic [15:0] cap;
        logic cap_flag;
        logic block;
        logic up;
    } tccu_state_t;

    tccu_state_t s_q;
    tccu_state_t s_d;

    logic [3:0] mode;
    logic is_pwm;
    logic dual_slope;
    logic pfc_mode;
    logic cap_is_top;
    logic [15:0] top_value;
    logic at_top;
    logic at_bottom;
    logic top_hit;
    logic bottom_hit;
    logic match_en;
    logic load_evt;
    logic fast_top_evt;
    logic [15:0] wdata16;

    logic [2:0] cmp_wr;
    logic [2:0] force_strobe;
    logic [2:0] flag_clear;
    logic [2:0] irq_ack;
    logic [2:0] irq_enable;
    logic [1:0] action [3];
    logic [15:0] cmp_active [3];
    logic [15:0] cmp_cpu [3];
    logic [2:0] match;
    logic [2:0] flag;
    logic [2:0] irq;
    logic [2:0] wave;
    logic [2:0] wave_ovr;

    assign mode = WAVEFORM_MODE_SELECT;
    assign wdata16 = {s_q.temp, BYTE_WDATA};

    // classify the waveform mode
    always_comb begin
        is_pwm = 1'b1;
        dual_slope = 1'b0;
        pfc_mode = 1'b0;
        cap_is_top = 1'b0;
        top_value = tccu_pkg::CNT_MAX;
        case (mode)
            tccu_pkg::MODE_NORMAL: is_pwm = 1'b0;
            tccu_pkg::MODE_RESERVED: is_pwm = 1'b0;
            tccu_pkg::MODE_CLR_CMPA: begin
                is_pwm = 1'b0;
                top_value = cmp_active[tccu_pkg::CH_A];
            end
            tccu_pkg::MODE_CLR_CAP: begin
                is_pwm = 1'b0;
                cap_is_top = 1'b1;
                top_value = s_q.cap;
            end
            tccu_pkg::MODE_PC8: begin
                dual_slope = 1'b1;
                top_value = tccu_pkg::TOP_8BIT;
            end
            tccu_pkg::MODE_PC9: begin
                dual_slope = 1'b1;
                top_value = tccu_pkg::TOP_9BIT;
            end
            tccu_pkg::MODE_PC10: begin
                dual_slope = 1'b1;
                top_value = tccu_pkg::TOP_10BIT;
            end
            tccu_pkg::MODE_FAST8: top_value = tccu_pkg::TOP_8BIT;
            tccu_pkg::MODE_FAST9: top_value = tccu_pkg::TOP_9BIT;
            tccu_pkg::MODE_FAST10: top_value = tccu_pkg::TOP_10BIT;
            tccu_pkg::MODE_PFC_CAP: begin
                dual_slope = 1'b1;
                pfc_mode = 1'b1;
                cap_is_top = 1'b1;
                top_value = s_q.cap;
            end
            tccu_pkg::MODE_PFC_CMPA: begin
                dual_slope = 1'b1;
                pfc_mode = 1'b1;
                top_value = cmp_active[tccu_pkg::CH_A];
            end
            tccu_pkg::MODE_PC_CAP: begin
                dual_slope = 1'b1;
                cap_is_top = 1'b1;
                top_value = s_q.cap;
            end
            tccu_pkg::MODE_PC_CMPA: begin
                dual_slope = 1'b1;
                top_value = cmp_active[tccu_pkg::CH_A];
            end
            tccu_pkg::MODE_FAST_CAP: begin
                cap_is_top = 1'b1;
                top_value = s_q.cap;
            end
            tccu_pkg::MODE_FAST_CMPA: top_value = cmp_active[tccu_pkg::CH_A];
            default: is_pwm = 1'b0;
        endcase
    end

    assign at_top = (s_q.cnt == top_value);
    assign at_bottom = (s_q.cnt == tccu_pkg::CNT_BOTTOM);
    // a counter write blocks every match, the top one included, for one tick
    assign match_en = TIMER_TICK && !s_q.block;
    assign top_hit = match_en && at_top;
    assign bottom_hit = match_en && at_bottom && !s_q.up;
    // phase-and-frequency-correct modes reload at bottom, the other pwm modes at top
    assign load_evt = pfc_mode ? bottom_hit : top_hit;
    assign fast_top_evt = is_pwm && !dual_slope && top_hit;

    always_comb begin
        s_d = s_q;
        // any high byte write loads the shared staging byte
        if (COMPARE_HIGH_WR_A || COMPARE_HIGH_WR_B || COMPARE_HIGH_WR_C
                || COUNT_HIGH_WR || CAPTURE_HIGH_WR) begin
            s_d.temp = BYTE_WDATA;
        end
        // counter sequencing on the timer tick
        if (TIMER_TICK) begin
            s_d.block = 1'b0;
            if (!dual_slope) begin
                s_d.up = 1'b1;
                s_d.cnt = (top_hit && mode != tccu_pkg::MODE_NORMAL) ? tccu_pkg::CNT_BOTTOM
                        : s_q.cnt + tccu_pkg::CNT_ONE;
            end else if (s_q.up) begin
                if (top_hit) begin
                    s_d.up = 1'b0;
                    s_d.cnt = s_q.cnt - tccu_pkg::CNT_ONE;
                end else begin
                    s_d.cnt = s_q.cnt + tccu_pkg::CNT_ONE;
                end
            end else begin
                if (at_bottom) begin
                    s_d.up = 1'b1;
                    s_d.cnt = s_q.cnt + tccu_pkg::CNT_ONE;
                end else begin
                    s_d.cnt = s_q.cnt - tccu_pkg::CNT_ONE;
                end
            end
        end
        // a cpu counter write overrides counting and arms the match block
        if (COUNT_LOW_WR) begin
            s_d.cnt = wdata16;
            s_d.block = 1'b1;
        end
        // capture register is cpu-writable only where it defines top
        if (cap_is_top) begin
            if (CAPTURE_LOW_WR) begin
                s_d.cap = wdata16;
            end
        end else if (CAPTURE_EVENT) begin
            s_d.cap = s_q.cnt;
        end
        if (CAPTURE_FLAG_CLEAR || CAPTURE_IRQ_ACK) begin
            s_d.cap_flag = 1'b0;
        end
        if (CAPTURE_EVENT && !cap_is_top) begin
            s_d.cap_flag = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q.cnt <= tccu_pkg::CNT_RESET;
            s_q.temp <= tccu_pkg::BYTE_RESET;
            s_q.cap <= tccu_pkg::CNT_RESET;
            s_q.cap_flag <= 1'b0;
            s_q.block <= 1'b0;
            s_q.up <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmp_wr = {COMPARE_LOW_WR_C, COMPARE_LOW_WR_B, COMPARE_LOW_WR_A};
    // strobes are used in the cycle they arrive and never stored
    assign force_strobe = {FORCE_COMPARE_STROBE_C, FORCE_COMPARE_STROBE_B,
                           FORCE_COMPARE_STROBE_A};
    assign flag_clear = {COMPARE_FLAG_CLEAR_C, COMPARE_FLAG_CLEAR_B, COMPARE_FLAG_CLEAR_A};
    assign irq_ack = {COMPARE_IRQ_ACK_C, COMPARE_IRQ_ACK_B, COMPARE_IRQ_ACK_A};
    assign irq_enable = {COMPARE_IRQ_ENABLE_C, COMPARE_IRQ_ENABLE_B, COMPARE_IRQ_ENABLE_A};
    assign action[0] = OUTPUT_ACTION_SELECT_A;
    assign action[1] = OUTPUT_ACTION_SELECT_B;
    assign action[2] = OUTPUT_ACTION_SELECT_C;

    genvar gi;
    generate
        for (gi = 0; gi < tccu_pkg::NUM_CH; gi++) begin : g_ch
            tccu_channel u_ch (
                .clk(CLK),
                .rst_n(RST_N),
                .wdata16(wdata16),
                .cmp_wr(cmp_wr[gi]),
                .dbuf_en(is_pwm),
                .load_evt(load_evt),
                .match_en(match_en),
                .top_evt(fast_top_evt),
                .counting_down(!s_q.up),
                .is_pwm(is_pwm),
                .dual_slope(dual_slope),
                .action(action[gi]),
                .force_strobe(force_strobe[gi]),
                .flag_clear(flag_clear[gi]),
                .irq_ack(irq_ack[gi]),
                .irq_enable(irq_enable[gi]),
                .count(s_q.cnt),
                .compare_active(cmp_active[gi]),
                .compare_cpu(cmp_cpu[gi]),
                .match(match[gi]),
                .flag(flag[gi]),
                .irq(irq[gi]),
                .wave(wave[gi]),
                .wave_override(wave_ovr[gi])
            );
        end
    endgenerate

    assign COUNT_VALUE = s_q.cnt;
    assign CAPTURE_VALUE = s_q.cap;
    assign CAPTURE_FLAG = s_q.cap_flag;
    assign CAPTURE_IRQ = s_q.cap_flag && CAPTURE_IRQ_ENABLE;
    assign COMPARE_VALUE_A = cmp_cpu[0];
    assign COMPARE_VALUE_B = cmp_cpu[1];
    assign COMPARE_VALUE_C = cmp_cpu[2];
    assign COMPARE_MATCH_A = match[0];
    assign COMPARE_MATCH_B = match[1];
    assign COMPARE_MATCH_C = match[2];
    assign COMPARE_FLAG_A = flag[0];
    assign COMPARE_FLAG_B = flag[1];
    assign COMPARE_FLAG_C = flag[2];
    assign COMPARE_IRQ_A = irq[0];
    assign COMPARE_IRQ_B = irq[1];
    assign COMPARE_IRQ_C = irq[2];
    assign WAVE_OUTPUT_A = wave[0];
    assign WAVE_OUTPUT_B = wave[1];
    assign WAVE_OUTPUT_C = wave[2];
    assign WAVE_OVERRIDE_A = wave_ovr[0];
    assign WAVE_OVERRIDE_B = wave_ovr[1];
    assign WAVE_OVERRIDE_C = wave_ovr[2];
endmodule : tccu_top

// file: bench/tccu_top_monitor.sv
// port-level assertion checker for the timer compare and capture unit
`timescale 1ns/100ps
module tccu_top_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TIMER_TICK,
    input wire logic [3:0] WAVEFORM_MODE_SELECT,
    input wire logic [1:0] OUTPUT_ACTION_SELECT_A,
    input wire logic COUNT_LOW_WR,
    input wire logic FORCE_COMPARE_STROBE_A,
    input wire logic COMPARE_IRQ_ACK_A,
    input wire logic [15:0] COUNT_VALUE,
    input wire logic [15:0] COMPARE_VALUE_A,
    input wire logic COMPARE_MATCH_A,
    input wire logic COMPARE_FLAG_A,
    input wire logic WAVE_OUTPUT_A,
    input wire logic WAVE_OVERRIDE_A
);
    // a counter write arms suppression until the next timer tick has passed
    logic blk_q;
    always_ff @(posedge CLK) begin
        if (!RST_N || COUNT_LOW_WR) begin
            blk_q <= RST_N;
        end else if (TIMER_TICK) begin
            blk_q <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_hit;
        TIMER_TICK && COMPARE_MATCH_A && !blk_q && !COUNT_LOW_WR;
    endsequence
    sequence s_blocked;
        TIMER_TICK && blk_q && !COUNT_LOW_WR && !COMPARE_FLAG_A;
    endsequence
    // cpu view equals the active value only outside the buffered modes
    property p_match;
        WAVEFORM_MODE_SELECT == 4'h0 |-> COMPARE_MATCH_A == (COUNT_VALUE == COMPARE_VALUE_A);
    endproperty
    a_match: assert property (p_match)
        else $error("match differs from counter equality");
    property p_flag_set; s_hit |=> COMPARE_FLAG_A; endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set one tick after match");
    property p_flag_late;
        $rose(COMPARE_FLAG_A) |-> $past(TIMER_TICK) && $past(COMPARE_MATCH_A);
    endproperty
    a_flag_late: assert property (p_flag_late)
        else $error("flag rose without a matching tick");
    property p_block; s_blocked |=> !COMPARE_FLAG_A; endproperty
    a_block: assert property (p_block)
        else $error("match after counter write was not suppressed");
    property p_ack;
        COMPARE_IRQ_ACK_A && !(TIMER_TICK && COMPARE_MATCH_A) |=> !COMPARE_FLAG_A;
    endproperty
    a_ack: assert property (p_ack)
        else $error("serviced interrupt left flag set");
    property p_force;
        FORCE_COMPARE_STROBE_A && !TIMER_TICK && !COUNT_LOW_WR && !COMPARE_FLAG_A
            |=> !COMPARE_FLAG_A && $stable(COUNT_VALUE);
    endproperty
    a_force: assert property (p_force)
        else $error("force touched flag or counter");
    property p_override; WAVE_OVERRIDE_A == (OUTPUT_ACTION_SELECT_A != 2'h0); endproperty
    a_override: assert property (p_override)
        else $error("pin override does not follow action setting");
    property p_wave_rst; @(posedge CLK) disable iff (1'b0) !RST_N |=> !WAVE_OUTPUT_A; endproperty
    a_wave_rst: assert property (p_wave_rst)
        else $error("waveform bit not cleared by reset");
endmodule : tccu_top_monitor

bind tccu_top tccu_top_monitor i_mon (.*);

// file: bench/tccu_cpu_model.sv
// cpu side model: byte-wide writes into the 16-bit timer registers
`timescale 1ns/100ps
module tccu_cpu_model (
    input wire logic CLK,
    output logic [7:0] BYTE_WDATA,
    output logic [4:0] hi_wr,
    output logic [4:0] lo_wr
);
    initial begin
        BYTE_WDATA = 8'hA5;
        hi_wr = 5'h00;
        lo_wr = 5'h00;
    end
    // target 0..2 compare a..c, 3 counter, 4 capture; bottom load only while down-counting
    task automatic wr16(input int t, input logic [15:0] v);
        @(posedge CLK);
        #1;
        hi_wr[t] = 1'b1;
        BYTE_WDATA = v[15:8];
        @(posedge CLK);
        #1;
        hi_wr[t] = 1'b0;
        lo_wr[t] = 1'b1;
        BYTE_WDATA = v[7:0];
        @(posedge CLK);
        #1;
        lo_wr[t] = 1'b0;
        // released bus shows the inverse so a stale byte cannot pass as valid
        BYTE_WDATA = ~BYTE_WDATA;
    endtask : wr16
endmodule : tccu_cpu_model

// file: bench/tccu_top_tb.sv
// self-checking bench for the timer compare and capture unit
`timescale 1ns/100ps
module tccu_top_tb;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic TIMER_TICK = 1'b0;
    logic CAPTURE_IRQ_ENABLE = 1'b0;
    logic [3:0] WAVEFORM_MODE_SELECT = 4'h0;
    logic [1:0] OUTPUT_ACTION_SELECT_A = 2'h0;
    logic [1:0] OUTPUT_ACTION_SELECT_B = 2'h0;
    logic [1:0] OUTPUT_ACTION_SELECT_C = 2'h0;
    logic COMPARE_IRQ_ENABLE_A = 1'b0;
    logic COMPARE_IRQ_ENABLE_B = 1'b0;
    logic COMPARE_IRQ_ENABLE_C = 1'b0;
    // 0-2 force, 3-5 flag clear, 6-8 ack, 9 capture, 10 capture clear, 11 capture ack
    logic [11:0] pls = 12'h000;
    logic [7:0] BYTE_WDATA;
    logic [4:0] hi_wr;
    logic [4:0] lo_wr;
    logic [15:0] COUNT_VALUE, CAPTURE_VALUE, COMPARE_VALUE_A, COMPARE_VALUE_B, COMPARE_VALUE_C;
    logic CAPTURE_FLAG, CAPTURE_IRQ, COMPARE_MATCH_A, COMPARE_MATCH_B, COMPARE_MATCH_C;
    logic COMPARE_FLAG_A, COMPARE_FLAG_B, COMPARE_FLAG_C;
    logic COMPARE_IRQ_A, COMPARE_IRQ_B, COMPARE_IRQ_C;
    logic WAVE_OUTPUT_A, WAVE_OUTPUT_B, WAVE_OUTPUT_C;
    logic WAVE_OVERRIDE_A, WAVE_OVERRIDE_B, WAVE_OVERRIDE_C;
    wire FORCE_COMPARE_STROBE_A = pls[0], FORCE_COMPARE_STROBE_B = pls[1];
    wire FORCE_COMPARE_STROBE_C = pls[2], COMPARE_FLAG_CLEAR_A = pls[3];
    wire COMPARE_FLAG_CLEAR_B = pls[4], COMPARE_FLAG_CLEAR_C = pls[5];
    wire COMPARE_IRQ_ACK_A = pls[6], COMPARE_IRQ_ACK_B = pls[7], COMPARE_IRQ_ACK_C = pls[8];
    wire CAPTURE_EVENT = pls[9], CAPTURE_FLAG_CLEAR = pls[10], CAPTURE_IRQ_ACK = pls[11];
    wire COMPARE_HIGH_WR_A = hi_wr[0], COMPARE_HIGH_WR_B = hi_wr[1];
    wire COMPARE_HIGH_WR_C = hi_wr[2], COUNT_HIGH_WR = hi_wr[3], CAPTURE_HIGH_WR = hi_wr[4];
    wire COMPARE_LOW_WR_A = lo_wr[0], COMPARE_LOW_WR_B = lo_wr[1];
    wire COMPARE_LOW_WR_C = lo_wr[2], COUNT_LOW_WR = lo_wr[3], CAPTURE_LOW_WR = lo_wr[4];
    wire [2:0] flags = {COMPARE_FLAG_A, COMPARE_FLAG_B, COMPARE_FLAG_C};
    wire [2:0] waves = {WAVE_OUTPUT_A, WAVE_OUTPUT_B, WAVE_OUTPUT_C};
    int fail_count = 0;
    int total_checks = 0;

    tccu_top i_dut (.*);
    tccu_cpu_model i_cpu (.*);

    always #2.5 CLK = ~CLK;

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic nx();
        @(posedge CLK);
        #1;
    endtask : nx
    task automatic pulse(input logic [11:0] m);
        nx();
        pls = m;
        nx();
        pls = 12'h000;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) begin
            nx();
            TIMER_TICK = 1'b1;
            nx();
            TIMER_TICK = 1'b0;
        end
    endtask : tick
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic t_match();
        OUTPUT_ACTION_SELECT_A = 2'h1;
        OUTPUT_ACTION_SELECT_B = 2'h2;
        OUTPUT_ACTION_SELECT_C = 2'h3;
        {COMPARE_IRQ_ENABLE_A, COMPARE_IRQ_ENABLE_B, COMPARE_IRQ_ENABLE_C} = 3'h7;
        for (int i = 0; i < 4; i++) begin
            i_cpu.wr16(i, (i == 3) ? 16'h0003 : 16'h0005);
        end
        chk("cmp_a", 16'h0005, COMPARE_VALUE_A);
        tick(2);
        chk("match", 16'h0007, {COMPARE_MATCH_A, COMPARE_MATCH_B, COMPARE_MATCH_C});
        chk("early", 16'h0000, flags);
        tick(1);
        chk("flags", 16'h0007, flags);
        chk("waves", 16'h0005, waves);
        chk("irq", 16'h0007, {COMPARE_IRQ_A, COMPARE_IRQ_B, COMPARE_IRQ_C});
        pulse(12'h1C0);
        chk("acked", 16'h0000, flags);
        $display("match test done");
    endtask : t_match
    task automatic t_block();
        i_cpu.wr16(3, 16'h0005);
        // timer stopped: the block waits for the next tick
        repeat (4) nx();
        tick(1);
        chk("blocked", 16'h0000, flags);
        chk("kept", 16'h0005, waves);
        chk("cmp_kept", 16'h0005, COMPARE_VALUE_A);
        chk("cmp_c", 16'h0005, COMPARE_VALUE_C);
        i_cpu.wr16(3, 16'h0004);
        tick(2);
        chk("rematch", 16'h0007, flags);
        chk("toggled", 16'h0001, waves);
        pulse(12'h038);
        chk("cleared", 16'h0000, flags);
        $display("block test done");
    endtask : t_block
    task automatic t_force();
        OUTPUT_ACTION_SELECT_C = 2'h1;
        pulse(12'h007);
        chk("forced", 16'h0004, waves);
        chk("no_flag", 16'h0000, flags);
        chk("no_count", 16'h0006, COUNT_VALUE);
        repeat (2) nx();
        chk("stateless", 16'h0004, waves);
        OUTPUT_ACTION_SELECT_A = 2'h0;
        #1;
        chk("ovr", 16'h0003, {WAVE_OVERRIDE_A, WAVE_OVERRIDE_B, WAVE_OVERRIDE_C});
        pulse(12'h001);
        chk("no_action", 16'h0004, waves);
        OUTPUT_ACTION_SELECT_A = 2'h1;
        WAVEFORM_MODE_SELECT = 4'h5;
        pulse(12'h007);
        chk("pwm_force", 16'h0004, waves);
        $display("force test done");
    endtask : t_force
    task automatic t_dbuf();
        i_cpu.wr16(0, 16'h0010);
        chk("buffer", 16'h0010, COMPARE_VALUE_A);
        i_cpu.wr16(3, 16'h0010);
        chk("old_active", 16'h0000, COMPARE_MATCH_A);
        i_cpu.wr16(3, 16'h00FE);
        tick(2);
        chk("wrap", 16'h0000, COUNT_VALUE);
        i_cpu.wr16(3, 16'h0010);
        chk("new_active", 16'h0001, COMPARE_MATCH_A);
        WAVEFORM_MODE_SELECT = 4'h4;
        i_cpu.wr16(0, 16'h0030);
        i_cpu.wr16(3, 16'h0030);
        chk("direct", 16'h0001, COMPARE_MATCH_A);
        i_cpu.wr16(3, 16'h002F);
        tick(2);
        chk("cm_clear", 16'h0000, COUNT_VALUE);
        chk("cm_flag", 16'h0001, COMPARE_FLAG_A);
        $display("buffer test done");
    endtask : t_dbuf
    task automatic t_top();
        WAVEFORM_MODE_SELECT = 4'h0;
        i_cpu.wr16(0, 16'h0020);
        WAVEFORM_MODE_SELECT = 4'hF;
        i_cpu.wr16(3, 16'h0020);
        tick(1);
        chk("past_top", 16'h0021, COUNT_VALUE);
        $display("top test done");
    endtask : t_top
    task automatic t_capture();
        // top stays fixed from here on while capturing
        WAVEFORM_MODE_SELECT = 4'h0;
        CAPTURE_IRQ_ENABLE = 1'b1;
        i_cpu.wr16(3, 16'h0100);
        pulse(12'h200);
        chk("cap", 16'h0100, CAPTURE_VALUE);
        chk("cap_irq", 16'h0001, CAPTURE_IRQ);
        tick(1);
        pulse(12'h200);
        chk("overwrite", 16'h0101, CAPTURE_VALUE);
        pulse(12'h400);
        chk("cap_clear", 16'h0000, CAPTURE_FLAG);
        pulse(12'h200);
        pulse(12'h800);
        chk("cap_ack", 16'h0000, CAPTURE_FLAG);
        $display("capture test done");
    endtask : t_capture

    initial begin
        repeat (5) @(posedge CLK);
        #1 RST_N = 1'b1;
        nx();
        chk("rst_wave", 16'h0000, waves);
        chk("rst_count", 16'h0000, COUNT_VALUE);
        t_match();
        t_block();
        t_force();
        t_dbuf();
        t_top();
        t_capture();
        print_verdict();
    end
    initial begin
        #20000;
        fail_count++;
        print_verdict();
    end
endmodule : tccu_top_tb
